// ===== hdl/sece_consts.vh
// Constants for the serial EEPROM command engine
`ifndef SECE_CONSTS_VH
`define SECE_CONSTS_VH
`define SECE_OP_SPECIAL 2'h0
`define SECE_OP_WRITE 2'h1
`define SECE_OP_READ 2'h2
`define SECE_OP_ERASE 2'h3
`define SECE_SUB_LOCK 2'h0
`define SECE_SUB_FILL 2'h1
`define SECE_SUB_CLEAR 2'h2
`define SECE_SUB_UNLOCK 2'h3
`define SECE_ADDR_W_WORD 4'h8
`define SECE_ADDR_W_BYTE 4'h9
`define SECE_WORDS 256
`define SECE_PROG_TIME_NS 5000000
`define SECE_CLK_PERIOD_NS 50
`define SECE_PROG_CYCLES (`SECE_PROG_TIME_NS / `SECE_CLK_PERIOD_NS)
`endif

// ===== hdl/sece_engine.v
// Serial EEPROM command engine with three-wire select/clock/data link
// What this block does
// - Serial input bits are sampled on each rising serial clock edge.
// - Serial output is tri-stated except during read data or busy/ready status.
// - When selected during programming, output low while busy, then high when ready.
// - A 1 on serial input while showing status tri-states the output.
// - Instruction is start bit, opcode, then address sized by organization.
// - Instructions are 11 to 12 bits long; seven instructions exist.
// - Opcodes decode read, erase, write and the four special commands.
// - Write and fill-array carry a 16- or 8-bit data field.
// - Read emits a dummy zero bit, then the word MSB first.
// - Read output bits change on rising serial clock edges.
// - Continued clocking streams following words, wrapping to address 0.
// - Only the first word of a sequential read has the dummy zero.
// - Write-enable latch clears at reset; programming commands need it set.
// - Latch stays set until reset or a lock instruction.
// - Reads execute regardless of the write-enable latch.
// - Write starts a self-timed clear-then-store on select falling.
// - Erase sets every bit of the addressed location to 1.
// - Programming completes with no further serial clocks.
// - Clear-array sets every bit in the array to 1.
// - Fill-array writes the data word into every location.
`include "sece_consts.vh"
module sece_engine #(
  parameter PROG_CYCLES = `SECE_PROG_CYCLES
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire chip_select_i,
  input wire serial_clock_i,
  input wire serial_in_i,
  input wire width_select_i,
  output reg serial_out_o,
  output reg serial_out_oe_n_o,
  output wire busy_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SHIFT = 3'h1;
  localparam ST_READ = 3'h2;
  localparam ST_ARMED = 3'h3;
  localparam ST_PROG = 3'h4;
  localparam ST_DONE = 3'h5;
  localparam ST_STATUS = 3'h6;
  localparam ST_FILL = 3'h7;

  // Array is kept as 256 bytes; word mode pairs bytes, high byte first
  reg [7:0] mem [0:`SECE_WORDS-1];

  reg [1:0] cs_sync_reg;
  reg [1:0] sk_sync_reg;
  reg [1:0] di_sync_reg;
  reg [1:0] ws_sync_reg;
  reg cs_d_reg;
  reg sk_d_reg;
  reg [2:0] state_reg;
  reg [4:0] cnt_reg;
  reg [1:0] op_reg;
  reg [8:0] addr_reg;
  reg [15:0] data_reg;
  reg [15:0] shout_reg;
  reg unlock_reg;
  reg [22:0] timer_reg;
  reg [8:0] fill_reg;
  reg [1:0] job_reg;
  reg [8:0] len_reg;
  reg org_byte_reg;

  wire cs = cs_sync_reg[1];
  wire sk = sk_sync_reg[1];
  wire di = di_sync_reg[1];
  wire sk_rise = sk & ~sk_d_reg;
  wire cs_fall = cs_d_reg & ~cs;
  wire cs_rise = cs & ~cs_d_reg;
  wire [3:0] aw = org_byte_reg ? `SECE_ADDR_W_BYTE : `SECE_ADDR_W_WORD;
  wire [4:0] dw = org_byte_reg ? 5'h08 : 5'h10;
  wire [1:0] sub = org_byte_reg ? addr_reg[8:7] : addr_reg[7:6];
  wire [8:0] addr_max = org_byte_reg ? 9'h0FF : 9'h07F;
  wire needs_data = (op_reg == `SECE_OP_WRITE) ||
    ((op_reg == `SECE_OP_SPECIAL) && (sub == `SECE_SUB_FILL));

  assign busy_o = (state_reg == ST_PROG) || (state_reg == ST_FILL);

  // Byte index of the first (high) byte of a location in the current organization
  function [7:0] byte_index;
    input [8:0] a;
    input is_byte;
    begin
      byte_index = is_byte ? a[7:0] : {a[6:0], 1'b0};
    end
  endfunction

  function [15:0] fetch;
    input [8:0] a;
    input is_byte;
    reg [7:0] i;
    begin
      i = byte_index(a, is_byte);
      fetch = is_byte ? {mem[i], 8'h00} : {mem[i], mem[i + 8'h01]};
    end
  endfunction

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_sync_reg <= 2'h0;
      sk_sync_reg <= 2'h0;
      di_sync_reg <= 2'h0;
      ws_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], chip_select_i};
      sk_sync_reg <= {sk_sync_reg[0], serial_clock_i};
      di_sync_reg <= {di_sync_reg[0], serial_in_i};
      ws_sync_reg <= {ws_sync_reg[0], width_select_i};
    end
  end

  // Memory has no reset: contents are nonvolatile
  always @(posedge ref_clk_i) begin
    if (state_reg == ST_PROG && timer_reg == 23'h000001) begin
      if (job_reg == 2'h1) begin
        mem[byte_index(addr_reg, org_byte_reg)] <=
          org_byte_reg ? data_reg[7:0] : data_reg[15:8];
        if (!org_byte_reg)
          mem[byte_index(addr_reg, 1'b0) + 8'h01] <= data_reg[7:0];
      end else if (job_reg == 2'h3) begin
        mem[byte_index(addr_reg, org_byte_reg)] <= 8'hFF;
        if (!org_byte_reg)
          mem[byte_index(addr_reg, 1'b0) + 8'h01] <= 8'hFF;
      end
    end
    if (state_reg == ST_FILL) begin
      if (job_reg == 2'h2)
        mem[fill_reg[7:0]] <= 8'hFF;
      else
        mem[fill_reg[7:0]] <= (org_byte_reg || fill_reg[0]) ?
          data_reg[7:0] : data_reg[15:8];
    end
  end

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_d_reg <= 1'b0;
      sk_d_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      op_reg <= 2'h0;
      addr_reg <= 9'h000;
      data_reg <= 16'h0000;
      shout_reg <= 16'h0000;
      unlock_reg <= 1'b0;
      timer_reg <= 23'h000000;
      fill_reg <= 9'h000;
      job_reg <= 2'h0;
      len_reg <= 9'h000;
      org_byte_reg <= 1'b0;
      serial_out_o <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end else begin
      cs_d_reg <= cs;
      sk_d_reg <= sk;
      case (state_reg)
        ST_IDLE: begin
          serial_out_oe_n_o <= 1'b1;
          // Strap is synchronised and only taken between frames
          org_byte_reg <= ws_sync_reg[1];
          if (cs && sk_rise && di) begin
            state_reg <= ST_SHIFT;
            cnt_reg <= 5'h00;
            addr_reg <= 9'h000;
          end
        end
        ST_SHIFT: begin
          if (!cs) begin
            state_reg <= ST_IDLE;
          end else if (sk_rise) begin
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg < 5'h02) begin
              op_reg <= {op_reg[0], di};
            end else if (cnt_reg < {1'b0, aw} + 5'h02) begin
              addr_reg <= {addr_reg[7:0], di};
            end else begin
              data_reg <= {data_reg[14:0], di};
            end
            if (cnt_reg == {1'b0, aw} + 5'h01) begin
              if (op_reg == `SECE_OP_READ) begin
                state_reg <= ST_READ;
                shout_reg <= fetch({addr_reg[7:0], di}, org_byte_reg);
                len_reg <= 9'h000;
                serial_out_o <= 1'b0;
                serial_out_oe_n_o <= 1'b0;
              end else if (op_reg == `SECE_OP_SPECIAL &&
                  (org_byte_reg ? addr_reg[7:6] : addr_reg[6:5])
                  == `SECE_SUB_UNLOCK) begin
                unlock_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end else if (op_reg == `SECE_OP_SPECIAL &&
                  (org_byte_reg ? addr_reg[7:6] : addr_reg[6:5])
                  == `SECE_SUB_LOCK) begin
                unlock_reg <= 1'b0;
                state_reg <= ST_IDLE;
              end else if (op_reg == `SECE_OP_ERASE ||
                  (op_reg == `SECE_OP_SPECIAL &&
                  (org_byte_reg ? addr_reg[7:6] : addr_reg[6:5])
                  == `SECE_SUB_CLEAR)) begin
                state_reg <= unlock_reg ? ST_ARMED : ST_IDLE;
              end
            end
            if (needs_data && cnt_reg == {1'b0, aw} + 5'h01 + dw)
              state_reg <= unlock_reg ? ST_ARMED : ST_IDLE;
          end
        end
        ST_READ: begin
          if (!cs) begin
            state_reg <= ST_IDLE;
            serial_out_oe_n_o <= 1'b1;
          end else if (sk_rise) begin
            serial_out_o <= shout_reg[15];
            if (len_reg == {4'h0, dw} - 9'h001) begin
              len_reg <= 9'h000;
              addr_reg <= (addr_reg == addr_max) ? 9'h000 :
                addr_reg + 9'h001;
              shout_reg <= fetch((addr_reg == addr_max) ? 9'h000 :
                addr_reg + 9'h001, org_byte_reg);
            end else begin
              len_reg <= len_reg + 9'h001;
              shout_reg <= {shout_reg[14:0], 1'b0};
            end
          end
        end
        ST_ARMED: begin
          // Extra clocks after a complete frame are ignored until select falls
          if (cs_fall) begin
            timer_reg <= PROG_CYCLES[22:0];
            fill_reg <= 9'h000;
            if (op_reg == `SECE_OP_WRITE) begin
              job_reg <= 2'h1;
              state_reg <= ST_PROG;
            end else if (op_reg == `SECE_OP_ERASE) begin
              job_reg <= 2'h3;
              state_reg <= ST_PROG;
            end else begin
              job_reg <= (sub == `SECE_SUB_CLEAR) ? 2'h2 : 2'h0;
              state_reg <= ST_FILL;
            end
          end
        end
        ST_FILL: begin
          fill_reg <= fill_reg + 9'h001;
          if (fill_reg == 9'h0FF)
            state_reg <= ST_PROG;
          // Status polling is served during the array sweep as well
          if (cs_rise) begin
            serial_out_o <= 1'b0;
            serial_out_oe_n_o <= 1'b0;
          end else if (!cs || (sk_rise && di)) begin
            serial_out_oe_n_o <= 1'b1;
          end
        end
        ST_PROG: begin
          // Runs on ref_clk only: serial clock not needed to finish
          timer_reg <= timer_reg - 23'h000001;
          if (cs_rise) begin
            serial_out_o <= 1'b0;
            serial_out_oe_n_o <= 1'b0;
          end else if (!cs) begin
            serial_out_oe_n_o <= 1'b1;
          end else if (sk_rise && di) begin
            serial_out_oe_n_o <= 1'b1;
          end
          if (timer_reg == 23'h000001) begin
            state_reg <= ST_DONE;
            if (cs && !serial_out_oe_n_o)
              serial_out_o <= 1'b1;
          end
        end
        ST_DONE: begin
          // Status stays high until the host deselects or clocks a 1
          if (cs && !(sk_rise && di)) begin
            serial_out_o <= 1'b1;
            serial_out_oe_n_o <= cs_rise ? 1'b0 : serial_out_oe_n_o;
            state_reg <= ST_STATUS;
          end else begin
            serial_out_oe_n_o <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_STATUS: begin
          if (!cs || (sk_rise && di)) begin
            serial_out_oe_n_o <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (cs_rise) begin
            serial_out_oe_n_o <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // sece_engine

// ===== testbench/sece_engine_assertions.sv
// Concurrent checks on the command engine ports
module sece_engine_assertions #(
  parameter PROG_CYCLES = 40
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire chip_select_i,
  input wire serial_clock_i,
  input wire serial_in_i,
  input wire width_select_i,
  input wire serial_out_o,
  input wire serial_out_oe_n_o,
  input wire busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  int busy_len;
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_o ? busy_len + 1 : 0;
    end
  end
  reset_idle_a: assert property (
    $fell(reset_i) |-> serial_out_oe_n_o && !busy_o)
    else $error("outputs not idle after reset");
  idle_tristate_a: assert property (
    (!chip_select_i)[*6] |-> serial_out_oe_n_o)
    else $error("output driven while deselected");
  enable_select_a: assert property (
    $fell(serial_out_oe_n_o) |-> $past(chip_select_i))
    else $error("output enabled without select");
  busy_low_a: assert property (
    busy_o && !serial_out_oe_n_o |-> !serial_out_o)
    else $error("status not low while busy");
  ready_high_a: assert property (
    $fell(busy_o) && chip_select_i && !serial_out_oe_n_o
    |-> ##[0:3] serial_out_o)
    else $error("status not high when ready");
  prog_time_a: assert property (
    $fell(busy_o) |-> busy_len >= PROG_CYCLES - 1
    && busy_len <= PROG_CYCLES + 260)
    else $error("programming time wrong");
  start_deselect_a: assert property (
    $rose(busy_o) |-> !chip_select_i)
    else $error("programming began while selected");
  out_steady_a: assert property (
    (chip_select_i && !serial_clock_i && !busy_o)[*6]
    |-> $stable(serial_out_o))
    else $error("output moved without clock rise");
  cover property ($fell(busy_o));
  cover property ($fell(serial_out_oe_n_o) && !busy_o);
  cover property (busy_o && !serial_out_oe_n_o);
endmodule // sece_engine_assertions
bind sece_engine sece_engine_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .chip_select_i(chip_select_i),
  .serial_clock_i(serial_clock_i), .serial_in_i(serial_in_i),
  .width_select_i(width_select_i), .serial_out_o(serial_out_o),
  .serial_out_oe_n_o(serial_out_oe_n_o), .busy_o(busy_o));

// ===== testbench/sece_host.sv
// Host-side model driving the select, clock and data lines
module sece_host (
  input wire logic ref_clk_i,
  input wire logic serial_out_i,
  output logic cs_o,
  output logic sk_o,
  output logic di_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got;
  initial begin
    cs_o = 1'b0;
    sk_o = 1'b0;
    di_o = 1'b0;
    got = 32'h0;
  end
  task automatic sel();
    @(posedge ref_clk_i) cs_o <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
  endtask
  // Output is sampled late in the low phase, before the rise moves it
  task automatic bit_x(input logic b);
    @(posedge ref_clk_i) di_o <= b;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i) got = {got[30:0], serial_out_i};
    @(posedge ref_clk_i) sk_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    sk_o <= 1'b0;
  endtask
  task automatic xfer(input logic [27:0] v, input int n, input int m);
    got = 32'h0;
    sel();
    for (int i = n - 1; i >= 0; i--) bit_x(v[i]);
    repeat (m) bit_x(1'b0);
  endtask
  // Released data line shows the inverse so a stale value cannot pass
  task automatic drop();
    @(posedge ref_clk_i) cs_o <= 1'b0;
    di_o <= ~di_o;
    repeat (8) @(posedge ref_clk_i);
  endtask
endmodule // sece_host

// ===== testbench/tb.sv
// Self-checking testbench for the serial EEPROM command engine
`include "sece_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic width_select_i = 1'b0;
  logic cs, sk, di;
  wire so, oe_n, busy;
  int fails = 0;
  int total_checks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  sece_engine #(.PROG_CYCLES(40)) u_dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .chip_select_i(cs), .serial_clock_i(sk),
    .serial_in_i(di), .width_select_i(width_select_i), .serial_out_o(so),
    .serial_out_oe_n_o(oe_n), .busy_o(busy));
  // A released output reads inverted, so data taken with the driver off fails
  sece_host u_host (.ref_clk_i(ref_clk_i), .serial_out_i(oe_n ? ~so : so),
    .cs_o(cs), .sk_o(sk), .di_o(di));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, string nm);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      close_out();
    end
  endtask
  task automatic prog(input logic [27:0] v, int n, logic b, string nm);
    u_host.xfer(v, n, 0);
    u_host.drop();
    @(negedge ref_clk_i);
    chk({31'h0, b}, {31'h0, busy}, nm);
    wait_idle();
  endtask
  task automatic rd(input logic [27:0] v, int n, int m, logic [31:0] e);
    u_host.xfer(v, n, m);
    u_host.drop();
    chk(e, m >= 32 ? u_host.got : u_host.got & ((32'h1 << m) - 1), "rdata");
  endtask
  task automatic t_locked();
    prog({1'b1, `SECE_OP_WRITE, 8'h05, 16'h1234}, 27, 0, "busy");
  endtask
  task automatic t_status();
    prog({1'b1, `SECE_OP_SPECIAL, `SECE_SUB_UNLOCK, 6'h0}, 11, 0,
      "busy");
    u_host.xfer({1'b1, `SECE_OP_WRITE, 8'h05, 16'hA5C3}, 27, 0);
    u_host.drop();
    u_host.sel();
    @(negedge ref_clk_i);
    chk(32'h0, {30'h0, oe_n, so}, "status busy");
    wait_idle();
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(32'h1, {30'h0, oe_n, so}, "status ready");
    u_host.bit_x(1'b1);
    @(negedge ref_clk_i);
    chk(32'h1, {31'h0, oe_n}, "oe_n");
    u_host.drop();
  endtask
  task automatic t_read();
    rd({1'b1, `SECE_OP_READ, 8'h05}, 11, 17, 32'h0A5C3);
  endtask
  task automatic t_wrap();
    prog({1'b1, `SECE_OP_WRITE, 8'hFF, 16'h0F0F}, 27, 1, "busy");
    prog({1'b1, `SECE_OP_WRITE, 8'h00, 16'h8001}, 27, 1, "busy");
    // Top address bit is a don't-care in word mode: 8'hFF and 8'h7F match
    rd({1'b1, `SECE_OP_READ, 8'h7F}, 11, 33, 32'h0F0F8001);
  endtask
  task automatic t_erase();
    prog({1'b1, `SECE_OP_ERASE, 8'h05}, 11, 1, "busy");
    rd({1'b1, `SECE_OP_READ, 8'h05}, 11, 17, 32'h0FFFF);
  endtask
  task automatic t_fill_lock();
    prog({1'b1, `SECE_OP_SPECIAL, `SECE_SUB_FILL, 6'h0, 16'h3C3C},
      27, 1, "busy");
    @(posedge ref_clk_i) width_select_i <= 1'b1;
    rd({1'b1, `SECE_OP_READ, 9'h00E}, 12, 9, 32'h03C);
    @(posedge ref_clk_i) width_select_i <= 1'b0;
    prog({1'b1, `SECE_OP_SPECIAL, `SECE_SUB_LOCK, 6'h0}, 11, 0,
      "busy");
    prog({1'b1, `SECE_OP_ERASE, 8'h07}, 11, 0, "busy");
    rd({1'b1, `SECE_OP_READ, 8'h07}, 11, 17, 32'h03C3C);
  endtask
  task automatic t_clear();
    prog({1'b1, `SECE_OP_SPECIAL, `SECE_SUB_UNLOCK, 6'h0}, 11, 0,
      "busy");
    prog({1'b1, `SECE_OP_SPECIAL, `SECE_SUB_CLEAR, 6'h0}, 11, 1,
      "busy");
    rd({1'b1, `SECE_OP_READ, 8'h07}, 11, 17, 32'h0FFFF);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    t_locked();
    t_status();
    t_read();
    t_wrap();
    t_erase();
    t_fill_lock();
    t_clear();
    close_out();
  end
endmodule // tb
